/* dtr_ctrl.sv */
// Request and trigger front end of an eight-channel DMA controller.
// Assumes an APB master on pclk and a transfer unit that moves one data
// unit per command (read then write, bus unlocked) and pulses when done.
//
// How it works
// RULE_01: each channel keeps a 7-bit trigger code
// RULE_02: code zero and reserved codes trigger nothing
// RULE_03: sixty-four hardware request lines form the pool
// RULE_04: software request bit per channel starts transfers
// RULE_05: transfer ends when the done interrupt fires
// RULE_06: data cycle is one read plus one write
// RULE_07: single mode does one cycle per request
// RULE_08: block mode runs the whole count per software request
// RULE_09: bus released after every data cycle
// RULE_10: higher priority request suspends lower channel
// RULE_11: per-channel address, count and control registers
// RULE_12: accepted request issues command from channel registers
// RULE_13: request in, acknowledge out, done interrupt out
// RULE_14: advanced addresses and counts written back
// RULE_15: eight channels numbered zero to seven
// RULE_16: fixed priority, channel zero highest
// RULE_17: dual addressing, read then write, unlocked
// RULE_18: nonzero code k routes request line k
`timescale 1ns/100ps
module dtr_ctrl (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic [7:0]            paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Hardware request pins
    input  wire logic [63:0]           hw_request_lines,
    // Data transfer unit
    output logic                       dtu_cmd_valid,
    output dtr_pkg::dtr_cmd_s          dtu_cmd,
    input  wire logic                  dtu_cmd_ready,
    input  wire logic                  dtu_cycle_done,
    // Per-channel outputs
    output logic [7:0]                 request_ack,
    output logic [7:0]                 channel_done_irq
);

    // ==========================================================
    // Channel registers
    logic [31:0]                src_addr [dtr_pkg::NCH];
    logic [31:0]                dst_addr [dtr_pkg::NCH];
    logic [dtr_pkg::CNT_W-1:0]  xfer_cnt [dtr_pkg::NCH];
    logic [dtr_pkg::CODE_W-1:0] trig_code [dtr_pkg::NCH];
    logic [7:0]                 block_mode;
    logic [7:0]                 sw_req;
    logic [7:0]                 hw_pend;
    logic [7:0]                 done_flag;

    dtr_pkg::dtr_state_e        state;
    logic [2:0]                 cur;
    logic [7:0]                 req;
    logic [7:0]                 trig_hit;
    logic [7:0]                 clr_sw;
    logic [7:0]                 clr_hw;
    logic [7:0]                 last_hit;
    logic                       grant_valid;
    logic [2:0]                 grant_idx;

    // ==========================================================
    // Pin synchroniser: a line counts once stages two and three agree.
    logic [63:0] sync1;
    logic [63:0] sync2;
    logic [63:0] sync3;
    logic [63:0] line_level;
    logic [63:0] line_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 64'h0;
            sync2 <= 64'h0;
            sync3 <= 64'h0;
        end else begin
            sync1 <= hw_request_lines; // RULE_03
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_level <= 64'h0;
        end else begin
            line_level <= (sync2 & sync3) | (line_level & (sync2 | sync3));
        end
    end

    assign line_rise = sync2 & sync3 & ~line_level;

    // ==========================================================
    // APB decode
    logic [2:0] a_ch;
    logic [4:0] a_off;
    logic       a_hit;
    logic       wr_en;

    assign a_ch  = paddr[7:5];
    assign a_off = {paddr[4:2], 2'b00};
    assign a_hit = (a_off == dtr_pkg::OFF_SRC_ADDR)
                || (a_off == dtr_pkg::OFF_DST_ADDR)
                || (a_off == dtr_pkg::OFF_XFER_CNT)
                || (a_off == dtr_pkg::OFF_CTRL)
                || (a_off == dtr_pkg::OFF_STATUS)
                || (a_off == dtr_pkg::OFF_TRIG_SEL);
    assign wr_en  = psel && penable && pwrite && a_hit;
    // Zero wait states keep the master simple; every access ends at once.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !a_hit;

    // Read data is captured in the setup cycle so it leaves a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            prdata <= 32'h0;
            if (!pwrite) begin
                case (a_off)
                    dtr_pkg::OFF_SRC_ADDR: prdata <= src_addr[a_ch];
                    dtr_pkg::OFF_DST_ADDR: prdata <= dst_addr[a_ch];
                    dtr_pkg::OFF_XFER_CNT: prdata <= {16'h0, xfer_cnt[a_ch]};
                    dtr_pkg::OFF_CTRL:     prdata <= {31'h0, block_mode[a_ch]};
                    dtr_pkg::OFF_STATUS: begin
                        prdata[dtr_pkg::ST_SW_REQ_BIT]  <= sw_req[a_ch];
                        prdata[dtr_pkg::ST_HW_PEND_BIT] <= hw_pend[a_ch];
                        prdata[dtr_pkg::ST_DONE_BIT]    <= done_flag[a_ch];
                        prdata[dtr_pkg::ST_BUSY_BIT]    <=
                            (state != dtr_pkg::DTR_IDLE) && (cur == a_ch);
                    end
                    dtr_pkg::OFF_TRIG_SEL: prdata <= {25'h0, trig_code[a_ch]};
                    default:               prdata <= 32'h0;
                endcase
            end
        end
    end

    // ==========================================================
    // Per-channel trigger routing and register update
    logic in_wb;
    assign in_wb = (state == dtr_pkg::DTR_WB);

    genvar c;
    generate
        for (c = 0; c < dtr_pkg::NCH; c++) begin : g_ch // RULE_15
            logic code_ok;
            logic wsel;
            logic wb_me;
            assign code_ok = (trig_code[c] != dtr_pkg::CODE_NONE)
                          && (trig_code[c] != dtr_pkg::CODE_RSV_A)
                          && (trig_code[c] != dtr_pkg::CODE_RSV_B)
                          && (trig_code[c] != dtr_pkg::CODE_RSV_C); // RULE_02
            assign trig_hit[c] = code_ok && !trig_code[c][6]
                              && line_rise[trig_code[c][5:0]]; // RULE_18
            assign wsel  = wr_en && (a_ch == 3'(c));
            assign wb_me = in_wb && (cur == 3'(c));
            assign last_hit[c] = (xfer_cnt[c] == 16'h0001);
            assign req[c] = (sw_req[c] || hw_pend[c])
                         && (xfer_cnt[c] != dtr_pkg::RST_CNT); // RULE_13
            // A block software request stays up until its count runs out.
            assign clr_sw[c] = wb_me && sw_req[c]
                && (block_mode[c] ? last_hit[c] : !hw_pend[c]); // RULE_08
            assign clr_hw[c] = wb_me && hw_pend[c]
                && !(block_mode[c] && sw_req[c]); // RULE_07

            // The engine wins over a software write of the same register.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    src_addr[c] <= dtr_pkg::RST_ADDR;
                    dst_addr[c] <= dtr_pkg::RST_ADDR;
                    xfer_cnt[c] <= dtr_pkg::RST_CNT;
                end else if (wb_me) begin
                    src_addr[c] <= src_addr[c] + dtr_pkg::ADDR_STEP; // RULE_14
                    dst_addr[c] <= dst_addr[c] + dtr_pkg::ADDR_STEP;
                    xfer_cnt[c] <= xfer_cnt[c] - 16'h0001;
                end else if (wsel) begin
                    if (a_off == dtr_pkg::OFF_SRC_ADDR) begin
                        src_addr[c] <= pwdata; // RULE_11
                    end
                    if (a_off == dtr_pkg::OFF_DST_ADDR) begin
                        dst_addr[c] <= pwdata;
                    end
                    if (a_off == dtr_pkg::OFF_XFER_CNT) begin
                        xfer_cnt[c] <= pwdata[15:0];
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    trig_code[c]  <= dtr_pkg::RST_CODE;
                    block_mode[c] <= 1'b0;
                end else if (wsel) begin
                    if (a_off == dtr_pkg::OFF_TRIG_SEL) begin
                        trig_code[c] <= pwdata[6:0]; // RULE_01
                    end
                    if (a_off == dtr_pkg::OFF_CTRL) begin
                        block_mode[c] <= pwdata[dtr_pkg::CTRL_BLOCK_BIT];
                    end
                end
            end

            // Sets win over clears for every flag below.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sw_req[c]    <= 1'b0;
                    hw_pend[c]   <= 1'b0;
                    done_flag[c] <= 1'b0;
                end else begin
                    sw_req[c] <= (sw_req[c] && !clr_sw[c])
                        || (wsel && a_off == dtr_pkg::OFF_STATUS
                            && pwdata[dtr_pkg::ST_SW_REQ_BIT]); // RULE_04
                    hw_pend[c] <= (hw_pend[c] && !clr_hw[c]) || trig_hit[c];
                    done_flag[c] <= (done_flag[c]
                        && !(wsel && a_off == dtr_pkg::OFF_STATUS
                             && pwdata[dtr_pkg::ST_DONE_BIT]))
                        || (wb_me && last_hit[c]);
                end
            end
        end
    endgenerate

    // ==========================================================
    // Arbitration
    dtr_prio_arb u_arb (
        .req         (req),
        .grant_valid (grant_valid),
        .grant_idx   (grant_idx)
    );

    // ==========================================================
    // Sequencer. Returning to idle after each unit lets a higher channel
    // cut in between two units of a lower channel's block.
    dtr_pkg::dtr_state_e next_state;

    always_comb begin
        next_state = state;
        case (state)
            dtr_pkg::DTR_IDLE: begin
                if (grant_valid) begin
                    next_state = dtr_pkg::DTR_CMD; // RULE_10
                end
            end
            dtr_pkg::DTR_CMD: begin
                if (dtu_cmd_ready) begin
                    next_state = dtr_pkg::DTR_WAIT;
                end
            end
            dtr_pkg::DTR_WAIT: begin
                if (dtu_cycle_done) begin
                    next_state = dtr_pkg::DTR_WB; // RULE_06
                end
            end
            dtr_pkg::DTR_WB:   next_state = dtr_pkg::DTR_IDLE; // RULE_09
            default:           next_state = dtr_pkg::DTR_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= dtr_pkg::DTR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= 3'h0;
        end else if (state == dtr_pkg::DTR_IDLE && grant_valid) begin
            cur <= grant_idx; // RULE_16
        end
    end

    // ==========================================================
    // Command to the transfer unit, one read and one write per command.
    assign dtu_cmd_valid = (state == dtr_pkg::DTR_CMD); // RULE_17
    always_comb begin
        dtu_cmd.src  = src_addr[cur]; // RULE_12
        dtu_cmd.dst  = dst_addr[cur];
        dtu_cmd.chan = cur;
    end

    // ==========================================================
    // Acknowledge and completion pulses, one cycle after write-back.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_ack      <= 8'h00;
            channel_done_irq <= 8'h00;
        end else begin
            request_ack      <= clr_hw; // RULE_13
            channel_done_irq <= in_wb ? (last_hit & (8'h01 << cur))
                                      : 8'h00; // RULE_05
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_accept;
        dtu_cmd_valid && dtu_cmd_ready;
    endsequence

    sequence s_wait_unit;
        !dtu_cmd_valid && (state == dtr_pkg::DTR_WAIT);
    endsequence

    AST_ONE_CMD: assert property ( // RULE_07
        s_accept |=> s_wait_unit)
        else $error("Command repeated after acceptance.");

    AST_TRIG_ZERO: assert property ( // RULE_02
        (trig_code[0] == dtr_pkg::CODE_NONE) |-> !trig_hit[0])
        else $error("Channel 0 triggered with code zero.");

    AST_ROUTE: assert property ( // RULE_18
        (trig_code[2] == 7'h0a && line_rise[10]) |=> hw_pend[2])
        else $error("Line 10 did not reach channel 2.");

    AST_CMD_HOLD: assert property ( // RULE_12
        (dtu_cmd_valid && !dtu_cmd_ready)
            |=> dtu_cmd_valid && $stable(dtu_cmd))
        else $error("Command dropped or changed before acceptance.");

    AST_CMD_SRC: assert property ( // RULE_12
        dtu_cmd_valid |-> dtu_cmd.src == src_addr[cur])
        else $error("Command source is not the channel source.");

    AST_RELEASE: assert property ( // RULE_09
        (state == dtr_pkg::DTR_WAIT && dtu_cycle_done)
            |=> in_wb ##1 (state == dtr_pkg::DTR_IDLE))
        else $error("Bus not released after a data unit.");

    AST_PRIO: assert property ( // RULE_16
        (state == dtr_pkg::DTR_IDLE && grant_valid)
            |-> ((req & ((8'h01 << grant_idx) - 8'h01)) == 8'h00))
        else $error("Lower channel granted over a higher one.");

    AST_DONE: assert property ( // RULE_05
        (in_wb && last_hit[cur]) |=> channel_done_irq != 8'h00)
        else $error("Last unit gave no completion interrupt.");

    AST_ACK: assert property ( // RULE_13
        (request_ack != 8'h00) |-> $past(in_wb))
        else $error("Acknowledge without a finished unit.");

    AST_WB_CNT: assert property ( // RULE_14
        in_wb |=> xfer_cnt[$past(cur)] == $past(xfer_cnt[cur]) - 16'h0001)
        else $error("Count not advanced after a unit.");

endmodule

/* dtr_ctrl_tb_top.sv */
// Self-checking bench for the DMA request front end.
// Assumes the design package and the transfer unit model are compiled first.
`timescale 1ns/100ps
module dtr_ctrl_tb_top;
    logic              pclk, presetn, psel, penable, pwrite, err, slow;
    logic              pready, pslverr, dtu_cmd_valid;
    logic              dtu_cmd_ready, dtu_cycle_done;
    logic [7:0]        paddr, request_ack, channel_done_irq;
    logic [31:0]       pwdata, prdata, rd;
    logic [63:0]       hw_request_lines;
    logic [31:0]       seed = 32'h31b5;
    dtr_pkg::dtr_cmd_s dtu_cmd;
    dtr_pkg::dtr_cmd_s got_q[$];
    int                miscompares, tests_run, pos, g;
    int                m_src[8], m_dst[8], m_cnt[8], m_irq[8];
    int                irq_n[8], ack_n[8];

    dtr_ctrl i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .hw_request_lines,
        .dtu_cmd_valid, .dtu_cmd, .dtu_cmd_ready, .dtu_cycle_done,
        .request_ack, .channel_done_irq);
    dtr_dtu_model i_dtu (.pclk, .presetn, .dtu_cmd_valid, .slow,
        .dtu_cmd_ready, .dtu_cycle_done);

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // ==========================================================
    // Monitors: accepted commands and per-channel pulses.
    always @(posedge pclk) begin
        if (presetn === 1'b1 && dtu_cmd_valid === 1'b1
            && dtu_cmd_ready === 1'b1)
            got_q.push_back(dtu_cmd);
        for (int i = 0; i < 8; i++) begin
            irq_n[i] += (channel_done_irq[i] === 1'b1);
            ack_n[i] += (request_ack[i] === 1'b1);
        end
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input int c, input logic [4:0] off,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= 8'(c * 32) | {3'b000, off};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic setup(input int c, input int n, input logic blk,
                         input logic [6:0] code);
        m_src[c] = rnd() & 32'hffff_fffc;
        m_dst[c] = rnd() & 32'hffff_fffc;
        m_cnt[c] = n;
        apb(1, c, dtr_pkg::OFF_SRC_ADDR, m_src[c]);
        apb(1, c, dtr_pkg::OFF_DST_ADDR, m_dst[c]);
        apb(1, c, dtr_pkg::OFF_XFER_CNT, 32'(n));
        apb(1, c, dtr_pkg::OFF_CTRL, {31'h0, blk});
        apb(1, c, dtr_pkg::OFF_TRIG_SEL, {25'h0, code});
    endtask

    task automatic sw(input int c);
        apb(1, c, dtr_pkg::OFF_STATUS, 32'h1 << dtr_pkg::ST_SW_REQ_BIT);
    endtask

    task automatic pulse(input int k);
        @(posedge pclk);
        hw_request_lines <= 64'h1 << k;
        repeat (4) @(posedge pclk);
        hw_request_lines <= '0;
    endtask

    // Pops one command and compares it with the channel's model state.
    task automatic take_any(output int c);
        dtr_pkg::dtr_cmd_s k;
        int n;
        n = 0;
        while (got_q.size() == 0 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        c = -1;
        if (got_q.size() == 0)
            check("cmd", 1, 0);
        else begin
            k = got_q.pop_front();
            c = int'(k.chan);
            check("src", m_src[c], k.src);
            check("dst", m_dst[c], k.dst);
            m_src[c] += dtr_pkg::ADDR_STEP;
            m_dst[c] += dtr_pkg::ADDR_STEP;
            m_cnt[c]--;
            if (m_cnt[c] == 0)
                m_irq[c]++;
        end
    endtask

    task automatic take(input int c);
        int k;
        take_any(k);
        check("chan", 32'(c), 32'(k));
    endtask

    task automatic settle();
        repeat (30) @(posedge pclk);
        check("extra", 0, 32'(got_q.size()));
        for (int c = 0; c < 8; c++) begin
            check("irq", 32'(m_irq[c]), 32'(irq_n[c]));
            apb(0, c, dtr_pkg::OFF_XFER_CNT, 0);
            check("count", 32'(m_cnt[c]), rd);
            apb(0, c, dtr_pkg::OFF_SRC_ADDR, 0);
            check("srcreg", 32'(m_src[c]), rd);
            apb(0, c, dtr_pkg::OFF_STATUS, 0);
            check("status", 32'(m_irq[c] > 0) << dtr_pkg::ST_DONE_BIT,
                  rd);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // A hang anywhere stops the run long after the real tests would finish.
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        tally_and_finish();
    end

    // ==========================================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hw_request_lines = 64'h0;
        slow = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int c = 0; c < 8; c++)
            for (int o = 0; o < 6; o++) begin
                apb(0, c, 5'(o * 4), 0);
                check("reset", 0, rd);
            end
        for (int o = 6; o < 8; o++) begin
            apb(1, 4, 5'(o * 4), rnd());
            check("errwr", 1, 32'(err));
            apb(0, 4, 5'(o * 4), 0);
            check("errrd", 1, 32'(err));
            check("unmapped", 0, rd);
        end
        for (int k = 0; k < 128; k++) begin
            apb(1, k % 8, dtr_pkg::OFF_TRIG_SEL, 32'(k));
            apb(0, k % 8, dtr_pkg::OFF_TRIG_SEL, 0);
            check("code", 32'(k), rd);
        end
        slow <= 1'(rnd());
        setup(3, 2, 1'b0, 7'h00);
        sw(3);
        take(3);
        settle();
        sw(3);
        take(3);
        settle();
        slow <= 1'(rnd());
        setup(6, 3, 1'b1, 7'h00);
        sw(6);
        repeat (3) take(6);
        settle();
        setup(5, 1, 1'b0, 7'h0a);
        setup(2, 1, 1'b0, 7'h0a);
        setup(1, 5, 1'b0, dtr_pkg::CODE_RSV_A);
        setup(0, 5, 1'b0, dtr_pkg::CODE_NONE);
        pulse(42);
        pulse(0);
        repeat (20) @(posedge pclk);
        check("untrig", 0, 32'(got_q.size()));
        pulse(10);
        take(2);
        take(5);
        settle();
        for (int c = 0; c < 8; c++)
            check("ack", 32'(c == 2 || c == 5), 32'(ack_n[c]));
        slow <= 1'b1;
        setup(7, 4, 1'b1, 7'h00);
        setup(0, 1, 1'b0, 7'h00);
        sw(7);
        take(7);
        sw(0);
        pos = 9;
        for (int i = 0; i < 4; i++) begin
            take_any(g);
            if (g == 0)
                pos = i;
        end
        check("suspend", 1, 32'(pos < 3));
        settle();
        tally_and_finish();
    end
endmodule

/* dtr_dtu_model.sv */
// Behavioural data transfer unit that sits behind the DMA request front end.
// Assumes commands arrive on a valid/ready pair clocked by pclk.
`timescale 1ns/100ps
module dtr_dtu_model (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Command side
    input  wire logic dtu_cmd_valid,
    input  wire logic slow,
    output logic      dtu_cmd_ready,
    output logic      dtu_cycle_done
);
    logic [2:0] wait_cnt;
    logic       busy;

    // ==========================================================
    // Handshake, then one read and one write per command.
    // A slow unit waits three cycles before each step, so the controller
    // meets both prompt and late answers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dtu_cmd_ready  <= 1'b0;
            dtu_cycle_done <= 1'b0;
            busy           <= 1'b0;
            wait_cnt       <= 3'd0;
        end else begin
            dtu_cycle_done <= 1'b0;
            if (dtu_cmd_ready) begin
                dtu_cmd_ready <= 1'b0;
                busy          <= 1'b1;
                wait_cnt      <= 3'd0;
            end else if (wait_cnt < (slow ? 3'd3 : 3'd0)) begin
                wait_cnt <= wait_cnt + 3'd1;
            end else if (busy) begin
                dtu_cycle_done <= 1'b1;
                busy           <= 1'b0;
                wait_cnt       <= 3'd0;
            end else if (dtu_cmd_valid) begin
                dtu_cmd_ready <= 1'b1;
            end
        end
    end
endmodule

/* dtr_pkg.sv */
// Shared constants, types and register map of the DMA request front end.
// Assumes a single 20 MHz APB clock and an 8-bit byte address space.
package dtr_pkg;

    // ==========================================================
    // Sizes
    localparam int NCH    = 8;
    localparam int NHW    = 64;
    localparam int CODE_W = 7;
    localparam int CNT_W  = 16;
    localparam int ADDR_W = 8;

    // ==========================================================
    // Register map: channel c sits at byte c * CH_STRIDE.
    localparam logic [7:0] CH_STRIDE     = 8'h20;
    localparam logic [4:0] OFF_SRC_ADDR  = 5'h00;
    localparam logic [4:0] OFF_DST_ADDR  = 5'h04;
    localparam logic [4:0] OFF_XFER_CNT  = 5'h08;
    localparam logic [4:0] OFF_CTRL      = 5'h0c;
    localparam logic [4:0] OFF_STATUS    = 5'h10;
    localparam logic [4:0] OFF_TRIG_SEL  = 5'h14;

    // Field positions.
    localparam int CTRL_BLOCK_BIT = 0;
    localparam int ST_SW_REQ_BIT  = 0;
    localparam int ST_HW_PEND_BIT = 1;
    localparam int ST_DONE_BIT    = 2;
    localparam int ST_BUSY_BIT    = 3;

    // Values after reset.
    localparam logic [31:0]       RST_ADDR = 32'h0000_0000;
    localparam logic [CNT_W-1:0]  RST_CNT  = 16'h0000;
    localparam logic [CODE_W-1:0] RST_CODE = 7'h00;

    // Trigger codes with special meaning.
    localparam logic [CODE_W-1:0] CODE_NONE  = 7'h00;
    localparam logic [CODE_W-1:0] CODE_RSV_A = 7'h2a;
    localparam logic [CODE_W-1:0] CODE_RSV_B = 7'h3e;
    localparam logic [CODE_W-1:0] CODE_RSV_C = 7'h3f;

    // Address advance after each data unit.
    localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        DTR_IDLE = 2'b00,
        DTR_CMD  = 2'b01,
        DTR_WAIT = 2'b11,
        DTR_WB   = 2'b10
    } dtr_state_e;

    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
        logic [2:0]  chan;
    } dtr_cmd_s;

endpackage

/* dtr_prio_arb.sv */
// Fixed-priority picker over the channel requests.
// Assumes requests are stable in the cycle in which the grant is used.
`timescale 1ns/100ps
module dtr_prio_arb (
    // Requests
    input  wire logic [7:0] req,
    // Grant
    output logic            grant_valid,
    output logic [2:0]      grant_idx
);

    // ==========================================================
    // Lowest index wins, so channel zero always goes first.
    always_comb begin
        grant_valid = |req;
        grant_idx   = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) begin
                grant_idx = 3'(i); // RULE_16
            end
        end
    end

endmodule
